/* File: hw/gdsp_pkg.sv */
// Constants and types for the gate driver serial register port
// How it works
// R1 - Frame is 5 command bits plus 11 data
// R2 - Reply carries 11 data bits, 5 ignored
// R3 - Master keeps clock low around select edges
// R4 - Master keeps select high 400 ns between frames
// R5 - Select high: ignore pins, float output
// R6 - Sample on falling, launch on rising edge
// R7 - Both words travel most significant bit first
// R8 - Master gives exactly sixteen clocks per frame
// R9 - Wrong bit count flags error, drops word
// R10 - Write frame returns old register contents
// R11 - Bit 15 flag, 14-11 address, 10-0 data
// R12 - Flag zero writes, flag one reads
// R13 - Read frame returns addressed register contents
// R14 - Reserved bits read and reset as zero
// R15 - Master avoids writing reserved or unlisted addresses
// R16 - Master sets lock field to block writes
// R17 - Fault clear bit clears latches, self-resets
// R18 - Summary fault bit ORs flags, mirrors pin
// R19 - Writes to status registers change nothing
package gdsp_pkg;
	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int DATA_BITS = 11;
	localparam int RW_BIT = 15;
	localparam int ADDR_MSB = 14;
	localparam int ADDR_LSB = 11;
	localparam int TX_MSB = 10;
	localparam int CNT_W = 5;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_LOAD = 5'h04;
	localparam logic [4:0] CNT_MAX = 5'h1f;
	localparam logic RW_WRITE = 1'h0;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_STAT1 = 4'h0;
	localparam logic [3:0] ADDR_STAT2 = 4'h1;
	localparam logic [3:0] ADDR_DRV = 4'h2;
	localparam logic [3:0] ADDR_HS = 4'h3;
	localparam logic [3:0] ADDR_LS = 4'h4;
	localparam logic [3:0] ADDR_OCP = 4'h5;
	localparam logic [3:0] ADDR_CSA = 4'h6;
	localparam logic [10:0] REG_RESET = 11'h000;
	localparam logic [10:0] REG_ZERO = 11'h000;
	localparam int CLR_BIT = 0;
	localparam int OTW_REP_BIT = 7;
	localparam int LOCK_MSB = 10;
	localparam int LOCK_LSB = 8;
	localparam logic [2:0] LOCK_CODE = 3'h6;
	localparam int ST2_OTW = 7;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [10:0] drv;
		logic [10:0] hs;
		logic [10:0] ls;
		logic [10:0] ocp;
		logic [10:0] csa;
	} gdsp_cfg_s;
	typedef struct packed {
		logic [9:0] prim;
		logic [10:0] sec;
	} gdsp_flt_s;
	typedef enum {fr_idle, fr_shift} gdsp_fr_e;
endpackage

/* File: hw/gdsp_port.sv */
// Serial register port of the gate driver
`timescale 1ns/1ps
module gdsp_port
	import gdsp_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic port_select_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire gdsp_flt_s fault_in,
	output gdsp_cfg_s cfg,
	output logic fault_out_n,
	output logic frame_error
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic sclk_m, sclk_q, sclk_d;
	logic cs_m, cs_q;
	logic sdi_m, sdi_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_m <= 1'b0;
			sclk_q <= 1'b0;
			sclk_d <= 1'b0;
			cs_m <= 1'b1;
			cs_q <= 1'b1;
			sdi_m <= 1'b0;
			sdi_q <= 1'b0;
		end else begin
			sclk_m <= sclk;
			sclk_q <= sclk_m;
			sclk_d <= sclk_q;
			cs_m <= port_select_n;
			cs_q <= cs_m;
			sdi_m <= sdi;
			sdi_q <= sdi_m;
		end
	end

	logic rise, fall, cs_act;
	assign rise = sclk_q & ~sclk_d;
	assign fall = ~sclk_q & sclk_d;
	assign cs_act = ~cs_q;

	// ----------------------------------------
	// State
	// ----------------------------------------
	gdsp_fr_e state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [FRAME_BITS-1:0] rx, next_rx;
	logic [DATA_BITS-1:0] tx, next_tx;
	logic next_sdo, next_sdo_oe, next_frame_error;
	gdsp_cfg_s next_cfg;
	logic [9:0] st1, next_st1;
	logic [10:0] st2, next_st2;
	logic next_fault_out_n;

	logic fault_sum, locked, end_frame, end_ok, clr;
	logic [3:0] ld_addr, wr_addr;
	logic [DATA_BITS-1:0] rd_data, wr_data;
	logic wr_en;

	// R18 summary fault
	assign fault_sum = (|st1) | (|st2[10:8]) | (|st2[6:0])
		| (st2[ST2_OTW] & cfg.drv[OTW_REP_BIT]);
	assign locked = (cfg.hs[LOCK_MSB:LOCK_LSB] == LOCK_CODE);
	assign ld_addr = {rx[2:0], sdi_q};
	// R11 field split
	assign wr_addr = rx[ADDR_MSB:ADDR_LSB];
	assign wr_data = rx[DATA_BITS-1:0];
	assign end_frame = (state == fr_shift) && !cs_act;
	// R1 R9 exact sixteen bits
	assign end_ok = end_frame && (cnt == CNT_FULL);
	// R12 flag zero writes; R16 lock blocks all but unlock path
	assign wr_en = end_ok && (rx[RW_BIT] == RW_WRITE) && (!locked || wr_addr == ADDR_HS);
	// R17 clear request
	assign clr = wr_en && (wr_addr == ADDR_DRV) && wr_data[CLR_BIT];

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always_comb begin
		// R13 addressed contents; R14 reserved reads zero
		if (ld_addr == ADDR_STAT1) begin
			rd_data = {fault_sum, st1};
		end else if (ld_addr == ADDR_STAT2) begin
			rd_data = st2;
		end else if (ld_addr == ADDR_DRV) begin
			rd_data = cfg.drv;
		end else if (ld_addr == ADDR_HS) begin
			rd_data = cfg.hs;
		end else if (ld_addr == ADDR_LS) begin
			rd_data = cfg.ls;
		end else if (ld_addr == ADDR_OCP) begin
			rd_data = cfg.ocp;
		end else if (ld_addr == ADDR_CSA) begin
			rd_data = cfg.csa;
		end else begin
			rd_data = REG_ZERO;
		end
	end

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_rx = rx;
		next_tx = tx;
		next_sdo = sdo;
		next_sdo_oe = sdo_oe;
		next_frame_error = 1'b0;
		case (state)
			fr_idle: begin
				// R5 pins ignored, output floats
				next_sdo_oe = 1'b0;
				if (cs_act) begin
					next_state = fr_shift;
					next_cnt = '0;
					next_rx = '0;
					next_tx = REG_ZERO;
					next_sdo = 1'b0;
					next_sdo_oe = 1'b1;
				end
			end
			fr_shift: begin
				if (!cs_act) begin
					next_state = fr_idle;
					next_sdo_oe = 1'b0;
					// R9 flag bad length
					next_frame_error = (cnt != CNT_FULL);
				end else if (fall) begin
					// R6 R7 sample on falling, MSB first
					next_rx = {rx[FRAME_BITS-2:0], sdi_q};
					if (cnt != CNT_MAX) begin
						next_cnt = cnt + 5'h01;
					end
					// R10 R2 old contents after command bits
					if (cnt == CNT_LOAD) begin
						next_tx = rd_data;
					end
				end else if (rise) begin
					// R6 R7 launch on rising, MSB first
					next_sdo = tx[TX_MSB];
					next_tx = {tx[DATA_BITS-2:0], 1'b0};
				end
			end
			default: begin
				next_state = fr_idle;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= fr_idle;
			cnt <= '0;
			rx <= '0;
			tx <= REG_ZERO;
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
			frame_error <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			rx <= next_rx;
			tx <= next_tx;
			sdo <= next_sdo;
			sdo_oe <= next_sdo_oe;
			frame_error <= next_frame_error;
		end
	end

	// ----------------------------------------
	// Registers and faults
	// ----------------------------------------
	always_comb begin
		next_cfg = cfg;
		// R19 status addresses not writable; R14 slot seven ignored
		if (wr_en) begin
			if (wr_addr == ADDR_DRV) begin
				next_cfg.drv = wr_data;
				// R17 clear bit never stored
				next_cfg.drv[CLR_BIT] = 1'b0;
			end else if (wr_addr == ADDR_HS) begin
				next_cfg.hs = wr_data;
			end else if (wr_addr == ADDR_LS) begin
				next_cfg.ls = wr_data;
			end else if (wr_addr == ADDR_OCP) begin
				next_cfg.ocp = wr_data;
			end else if (wr_addr == ADDR_CSA) begin
				next_cfg.csa = wr_data;
			end
		end
		// R17 clear latches, new events win
		next_st1 = (clr ? 10'h000 : st1) | fault_in.prim;
		next_st2 = (clr ? 11'h000 : st2) | fault_in.sec;
		// R18 pin mirrors summary
		next_fault_out_n = ~fault_sum;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cfg <= {5{REG_RESET}};
			st1 <= 10'h000;
			st2 <= 11'h000;
			fault_out_n <= 1'b1;
		end else begin
			cfg <= next_cfg;
			st1 <= next_st1;
			st2 <= next_st2;
			fault_out_n <= next_fault_out_n;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	property p_hiz_idle;
		(state == fr_idle) && !cs_act |=> !sdo_oe;
	endproperty
	a_hiz_idle: assert property (p_hiz_idle) else $error("output driven while deselected"); // R5

	property p_bad_len;
		end_frame && (cnt != CNT_FULL) |=> frame_error && $stable(cfg);
	endproperty
	a_bad_len: assert property (p_bad_len) else $error("bad frame not rejected"); // R9

	property p_good_len;
		end_ok |=> !frame_error;
	endproperty
	a_good_len: assert property (p_good_len) else $error("good frame flagged"); // R1

	property p_load;
		(state == fr_shift) && cs_act && fall && (cnt == CNT_LOAD) |=> tx == $past(rd_data);
	endproperty
	a_load: assert property (p_load) else $error("reply not loaded"); // R10

	property p_launch;
		(state == fr_shift) && cs_act && rise |=> sdo == $past(tx[TX_MSB]);
	endproperty
	a_launch: assert property (p_launch) else $error("wrong bit launched"); // R7

	property p_rsvd_zero;
		(ld_addr == 4'h7) |-> rd_data == REG_ZERO;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved slot not zero"); // R14

	property p_write;
		wr_en && (wr_addr == ADDR_LS) |=> cfg.ls == $past(wr_data);
	endproperty
	a_write: assert property (p_write) else $error("write not applied"); // R12

	property p_status_ro;
		end_ok && (wr_addr == ADDR_STAT1 || wr_addr == ADDR_STAT2) |=> $stable(cfg);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write changed config"); // R19

	property p_clear;
		clr && (fault_in == '0) |=> (st1 == 10'h000) && (st2 == 11'h000) ##1 fault_out_n;
	endproperty
	a_clear: assert property (p_clear) else $error("faults not cleared"); // R17

	property p_mirror;
		##1 fault_out_n == !$past(fault_sum);
	endproperty
	a_mirror: assert property (p_mirror) else $error("fault pin not mirroring"); // R18

	property p_clr_self;
		1'b1 |-> !cfg.drv[CLR_BIT];
	endproperty
	a_clr_self: assert property (p_clr_self) else $error("clear bit stuck"); // R17

	property p_locked;
		end_ok && locked && (wr_addr != ADDR_HS) |=> $stable(cfg);
	endproperty
	a_locked: assert property (p_locked) else $error("write passed lock"); // R16

	property p_lead_zero;
		(state == fr_shift) && cs_act && rise && (cnt <= CNT_LOAD) |=> !sdo;
	endproperty
	a_lead_zero: assert property (p_lead_zero) else $error("command slots not zero"); // R2

	property p_set_wins;
		clr |=> (st1 == $past(fault_in.prim)) && (st2 == $past(fault_in.sec));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost on clear"); // R17

	c_write: cover property (wr_en);
	c_read: cover property (end_ok && rx[RW_BIT]);
	c_error: cover property (frame_error);
	c_clear: cover property (clr);
	c_blocked: cover property (end_ok && locked && (wr_addr != ADDR_HS));
endmodule

/* File: verification/gdsp_master.sv */
// Serial master model for the register port
`timescale 1ns/1ps
module gdsp_master (
	input wire logic mclk,
	output logic sclk,
	output logic port_select_n,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sclk = 1'h0;
		port_select_n = 1'h1;
		sdi = 1'h0;
	end
	// ----------------------------------------
	// One frame of n clocks
	// ----------------------------------------
	task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'h0;
		@(negedge mclk);
		port_select_n = 1'h0;
		#160;
		for (int i = 0; i < n; i++) begin
			sclk = 1'h1;
			sdi = (i < 16) ? w[15 - i] : ~sdi;
			#160;
			sclk = 1'h0;
			r = {r[14:0], sdo};
			#160;
		end
		port_select_n = 1'h1;
		repeat (12) begin
			@(negedge mclk);
			sdi = ~sdi;
		end
	endtask
endmodule

/* File: verification/tb_top.sv */
// Testbench for the serial register port
`timescale 1ns/1ps
module tb_top;
	import gdsp_pkg::*;
	logic mclk = 1'h0;
	logic reset_n = 1'h0;
	logic sclk, port_select_n, sdi, sdo, sdo_oe, fault_out_n, frame_error;
	gdsp_flt_s fault_in = '0;
	gdsp_cfg_s cfg;
	int fails = 0;
	int tests_run = 0;
	int ferr = 0;
	logic [15:0] r;
	logic [10:0] v;
	always #20 mclk = ~mclk;
	always @(negedge mclk) begin
		if (frame_error === 1'h1) begin
			ferr++;
		end
	end
	gdsp_port uut (.mclk(mclk), .reset_n(reset_n), .sclk(sclk),
		.port_select_n(port_select_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
		.fault_in(fault_in), .cfg(cfg), .fault_out_n(fault_out_n),
		.frame_error(frame_error));
	gdsp_master m (.mclk(mclk), .sclk(sclk), .port_select_n(port_select_n),
		.sdi(sdi), .sdo(sdo_oe ? sdo : ~sdo));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string s, input logic [54:0] e, input logic [54:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic xf(input logic rw, input logic [3:0] a, input logic [10:0] d,
		input logic [10:0] e);
		m.frame({rw, a, d}, 16, r);
		chk("reply", {44'h0, e}, {39'h0, r});
		chk("sdo_oe", 55'h0, {54'h0, sdo_oe});
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#1000000;
		fails++;
		conclude();
	end
	initial begin
		repeat (20) @(negedge mclk);
		reset_n = 1'h1;
		repeat (4) @(negedge mclk);
		chk("fault_out_n", 55'h1, {54'h0, fault_out_n});
		for (int a = 0; a < 8; a++) begin
			xf(1'h1, a[3:0], 11'h7ff, 11'h0);
		end
		for (int p = 0; p < 2; p++) begin
			for (int a = 2; a < 7; a++) begin
				v = {a[2:0], p ? 8'ha4 : 8'h5a};
				xf(1'h0, a[3:0], v, p ? {a[2:0], 8'h5a} : 11'h0);
				xf(1'h1, a[3:0], 11'h7ff, v);
			end
		end
		chk("cfg", {11'h2a4, 11'h3a4, 11'h4a4, 11'h5a4, 11'h6a4}, cfg);
		@(negedge mclk);
		fault_in = 21'h4001;
		@(negedge mclk);
		fault_in = '0;
		repeat (3) @(negedge mclk);
		chk("fault_out_n", 55'h0, {54'h0, fault_out_n});
		xf(1'h1, ADDR_STAT1, 11'h0, 11'h408);
		xf(1'h0, ADDR_STAT1, 11'h7ff, 11'h408);
		xf(1'h0, ADDR_STAT2, 11'h7ff, 11'h001);
		xf(1'h0, 4'h7, 11'h7ff, 11'h0);
		xf(1'h1, ADDR_STAT2, 11'h0, 11'h001);
		xf(1'h0, ADDR_DRV, 11'h2a5, 11'h2a4);
		xf(1'h1, ADDR_STAT1, 11'h0, 11'h0);
		xf(1'h1, ADDR_STAT2, 11'h0, 11'h0);
		xf(1'h1, ADDR_DRV, 11'h0, 11'h2a4);
		chk("fault_out_n", 55'h1, {54'h0, fault_out_n});
		@(negedge mclk);
		fault_in = 21'h00080;
		@(negedge mclk);
		fault_in = '0;
		repeat (3) @(negedge mclk);
		chk("fault_out_n", 55'h0, {54'h0, fault_out_n});
		xf(1'h1, ADDR_STAT1, 11'h0, 11'h400);
		xf(1'h1, ADDR_STAT2, 11'h0, 11'h080);
		xf(1'h0, ADDR_DRV, 11'h221, 11'h2a4);
		@(negedge mclk);
		fault_in = 21'h00080;
		@(negedge mclk);
		fault_in = '0;
		repeat (3) @(negedge mclk);
		chk("fault_out_n", 55'h1, {54'h0, fault_out_n});
		xf(1'h1, ADDR_STAT1, 11'h0, 11'h000);
		xf(1'h0, ADDR_DRV, 11'h2a5, 11'h220);
		xf(1'h1, ADDR_STAT2, 11'h0, 11'h000);
		m.frame({RW_WRITE, ADDR_LS, 11'h111}, 15, r);
		m.frame({RW_WRITE, ADDR_LS, 11'h111}, 17, r);
		xf(1'h1, ADDR_LS, 11'h0, 11'h4a4);
		chk("frame_errors", 55'h2, 55'(ferr));
		xf(1'h0, ADDR_HS, {LOCK_CODE, 8'h0}, 11'h3a4);
		xf(1'h0, ADDR_LS, 11'h0, 11'h4a4);
		xf(1'h1, ADDR_LS, 11'h0, 11'h4a4);
		xf(1'h0, ADDR_HS, 11'h0, 11'h600);
		xf(1'h0, ADDR_LS, 11'h0, 11'h4a4);
		xf(1'h1, ADDR_LS, 11'h0, 11'h0);
		reset_n = 1'h0;
		repeat (2) @(negedge mclk);
		reset_n = 1'h1;
		repeat (4) @(negedge mclk);
		chk("cfg", 55'h0, cfg);
		xf(1'h1, ADDR_CSA, 11'h0, 11'h0);
		conclude();
	end
endmodule
